// >>> afaf_consts.svh
// constants for the adaptive flow average filter
`ifndef AFAF_CONSTS_SVH
`define AFAF_CONSTS_SVH
// register offsets (byte addresses)
`define AFAF_OFF_WINDOW 8'h00
`define AFAF_OFF_AFACTOR 8'h04
`define AFAF_OFF_CUTOFF 8'h08
`define AFAF_OFF_PLAIN 8'h0C
`define AFAF_OFF_ADAPTIVE 8'h10
`define AFAF_OFF_STATUS 8'h14
// setting limits and reset values
`define AFAF_MAX_SETTING 7'h63
`define AFAF_RST_WINDOW 7'h01
`define AFAF_RST_AFACTOR 7'h00
`define AFAF_RST_CUTOFF 16'h0001
// band width is cutoff shifted left by this
`define AFAF_BAND_SHIFT 1
// exponential coefficient as a right shift (1/2 per sample)
`define AFAF_EXP_SHIFT 1
// status field positions
`define AFAF_ST_ACCEL 0
`define AFAF_ST_FULL 1
`endif

// >>> afaf_pkg.sv
// types for the adaptive flow average filter
package afaf_pkg;
   typedef enum logic [1:0] {
      AFAF_IDLE = 2'b00,
      AFAF_CALC = 2'b01,
      AFAF_DONE = 2'b11
   } afaf_state_t;
endpackage

// >>> afaf_filter.sv
// adaptive flow average filter: moving average plus acceleration tracking
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "afaf_consts.svh"

// Notes on behaviour
// - ratio is whole bands from reference; accumulate
// - bands counted both above and below reference
// - threshold exceeded: new reference from next sample
// - new reference equals last filtered output
// - inside first band: clear ratio, accumulator, rereference
// - accelerating output follows raw exponentially
// - threshold zero leaves plain average only
// - threshold setting limited to 99
// - window one passes raw sample straight through
// - window setting limited to 99 samples
// - plain output is mean of last window samples
// - one sample per period, default fifteen seconds
// - band width is twice the low-flow cutoff
// - threshold exceeded: averaging window restarts at raw
module afaf_filter #(
   parameter int DW = 16,
   parameter int MAXW = 99,
   parameter int PERIOD_S = 15,
   parameter int CLK_HZ = 25000000,
   parameter longint PERIOD_CYC = 64'(PERIOD_S) * 64'(CLK_HZ)
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // raw sample stream (same clock domain, signed flow)
   input wire logic sampleValid,
   input wire logic signed [DW-1:0] sampleData,
   // filtered results
   output logic outValid,
   output logic signed [DW-1:0] plainAverageOutput,
   output logic signed [DW-1:0] adaptiveAverageOutput,
   output logic periodTick
);
   import afaf_pkg::*;

   localparam int AW = DW + 8;

   logic [6:0] windowLen;
   logic [6:0] aFactor;
   logic [15:0] cutoff;
   logic signed [DW-1:0] buffer [0:MAXW-1];
   logic [6:0] wrPtr;
   logic [6:0] fillCount;
   logic signed [AW-1:0] runSum;
   logic signed [DW-1:0] refFlow;
   logic [7:0] accum;
   logic accel;
   logic pendRef;
   logic [63:0] periodCnt;
   afaf_state_t state;
   logic signed [DW-1:0] latched;

   // settings; window and threshold writes above 99 are clamped so the filter stays in range
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         windowLen <= `AFAF_RST_WINDOW;
         aFactor <= `AFAF_RST_AFACTOR;
         cutoff <= `AFAF_RST_CUTOFF;
      end else if (regWr) begin
         case (regAddr)
            `AFAF_OFF_WINDOW: begin
               // compare the whole word so high bits cannot wrap small
               if (regWdata > 32'(`AFAF_MAX_SETTING)) begin
                  windowLen <= `AFAF_MAX_SETTING;
               end else if (regWdata == 32'h0000_0000) begin
                  windowLen <= 7'h01;
               end else begin
                  windowLen <= regWdata[6:0];
               end
            end
            `AFAF_OFF_AFACTOR: begin
               if (regWdata > 32'(`AFAF_MAX_SETTING)) begin
                  aFactor <= `AFAF_MAX_SETTING;
               end else begin
                  aFactor <= regWdata[6:0];
               end
            end
            `AFAF_OFF_CUTOFF: cutoff <= regWdata[15:0];
            default: ;
         endcase
      end
   end

   // read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regRdata <= 32'h0000_0000;
      end else if (regRd) begin
         case (regAddr)
            `AFAF_OFF_WINDOW: regRdata <= {25'h0, windowLen};
            `AFAF_OFF_AFACTOR: regRdata <= {25'h0, aFactor};
            `AFAF_OFF_CUTOFF: regRdata <= {16'h0, cutoff};
            `AFAF_OFF_PLAIN: regRdata <= 32'(plainAverageOutput);
            `AFAF_OFF_ADAPTIVE: regRdata <= 32'(adaptiveAverageOutput);
            `AFAF_OFF_STATUS:
               regRdata <= {30'h0, fillCount >= windowLen, accel};
            default: regRdata <= 32'h0000_0000;
         endcase
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   // measurement period tick for the front end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         periodCnt <= 64'h0000_0000_0000_0000;
         periodTick <= 1'b0;
      end else if (periodCnt >= PERIOD_CYC - 64'd1) begin
         periodCnt <= 64'h0000_0000_0000_0000;
         periodTick <= 1'b1;
      end else begin
         periodCnt <= periodCnt + 64'd1;
         periodTick <= 1'b0;
      end
   end

   // band arithmetic for the current sample
   logic signed [DW:0] diff;
   logic [DW:0] absDiff;
   logic [17:0] band;
   logic [DW:0] ratioWide;
   logic [7:0] ratio;
   logic [8:0] accSum;
   logic over;
   always_comb begin
      diff = (DW+1)'(latched) - (DW+1)'(refFlow);
      absDiff = diff[DW] ? (DW+1)'(-diff) : (DW+1)'(diff);
      band = {2'b00, cutoff} << `AFAF_BAND_SHIFT;
      ratioWide = (band == 18'h0_0000) ? '0 : (DW+1)'(absDiff / band);
      ratio = (ratioWide > (DW+1)'(255)) ? 8'hFF : ratioWide[7:0];
      accSum = {1'b0, accum} + {1'b0, ratio};
      over = (aFactor != 7'h00) && (accSum > {2'b00, aFactor});
   end

   // sequencing: take sample, then update in one calc cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= AFAF_IDLE;
         latched <= '0;
      end else begin
         case (state)
            AFAF_IDLE: begin
               if (sampleValid) begin
                  latched <= sampleData;
                  state <= AFAF_CALC;
               end
            end
            AFAF_CALC: state <= AFAF_DONE;
            AFAF_DONE: state <= AFAF_IDLE;
            default: state <= AFAF_IDLE;
         endcase
      end
   end

   // next window sum and fill, so the mean already holds this sample
   // index math runs in 8 bits: pointer plus depth overflows 7 bits
   logic full;
   logic [7:0] oldIdx;
   logic signed [AW-1:0] nextSum;
   logic [6:0] nextFill;
   always_comb begin
      full = (fillCount >= windowLen);
      oldIdx = (8'(wrPtr) + 8'(MAXW) - 8'(windowLen)) % 8'(MAXW);
      if (over) begin
         nextSum = AW'(latched);
         nextFill = 7'h01;
      end else if (full) begin
         // oldest sample leaves as the new one enters
         nextSum = runSum + AW'(latched) - AW'(buffer[7'(oldIdx)]);
         nextFill = fillCount;
      end else begin
         nextSum = runSum + AW'(latched);
         nextFill = fillCount + 7'h01;
      end
   end

   // moving average window; restarts at raw on a real change
   // limitation: shrinking the window while full drops only one entry
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrPtr <= 7'h00;
         fillCount <= 7'h00;
         runSum <= '0;
      end else if (state == AFAF_CALC) begin
         runSum <= nextSum;
         fillCount <= nextFill;
         if (over) begin
            wrPtr <= 7'h01;
         end else begin
            wrPtr <= (wrPtr == 7'(MAXW - 1)) ? 7'h00 : wrPtr + 7'h01;
         end
      end
   end

   // sample memory, one entry per slot
   always_ff @(posedge clk) begin
      if (state == AFAF_CALC) begin
         buffer[over ? 7'h00 : wrPtr] <= latched;
      end
   end

   // mean of held samples; window of one is the raw value
   logic signed [AW-1:0] mean;
   always_comb begin
      if (windowLen == 7'h01) begin
         mean = AW'(latched);
      end else begin
         mean = AW'(nextSum / $signed({1'b0, AW'(nextFill)}));
      end
   end

   // acceleration detector and reference tracking
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         accum <= 8'h00;
         refFlow <= '0;
         accel <= 1'b0;
         pendRef <= 1'b0;
      end else if (state == AFAF_CALC) begin
         if (pendRef) begin
            // reference moves on the sample after the crossing
            refFlow <= adaptiveAverageOutput;
            pendRef <= 1'b0;
         end
         if (aFactor == 7'h00) begin
            accum <= 8'h00;
            accel <= 1'b0;
         end else if (ratio == 8'h00) begin
            accum <= 8'h00;
            accel <= 1'b0;
            pendRef <= 1'b1;
         end else if (over) begin
            accum <= 8'h00;
            accel <= 1'b1;
            pendRef <= 1'b1;
         end else begin
            accum <= accSum[8] ? 8'hFF : accSum[7:0];
            accel <= 1'b1;
         end
      end
   end

   // outputs; accelerating path steps half way toward raw
   logic signed [DW-1:0] newPlain;
   logic signed [DW:0] step;
   always_comb begin
      newPlain = over ? latched : DW'(mean);
      step = ((DW+1)'(latched) - (DW+1)'(adaptiveAverageOutput))
         >>> `AFAF_EXP_SHIFT;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         plainAverageOutput <= '0;
         adaptiveAverageOutput <= '0;
         outValid <= 1'b0;
      end else begin
         outValid <= (state == AFAF_CALC);
         if (state == AFAF_CALC) begin
            plainAverageOutput <= newPlain;
            if (windowLen == 7'h01) begin
               adaptiveAverageOutput <= latched;
            end else if (aFactor != 7'h00 && ratio != 8'h00) begin
               adaptiveAverageOutput <=
                  DW'((DW+1)'(adaptiveAverageOutput) + step);
            end else begin
               adaptiveAverageOutput <= newPlain;
            end
         end
      end
   end

   // output becomes valid two cycles after a taken sample
   tick_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_IDLE && sampleValid) |-> ##2 outValid)
      else $error("output valid missing");
   onevalid_a: assert property (@(posedge clk) disable iff (!resetn)
      outValid |=> !outValid)
      else $error("output valid too long");
   // read data only stands after a read strobe
   rdidle_a: assert property (@(posedge clk) disable iff (!resetn)
      !regRd |=> regRdata == 32'h0000_0000)
      else $error("read data without strobe");

   // settings stay inside their legal range, then the output and crossing rules
   clamp_a: assert property (@(posedge clk) disable iff (!resetn)
      windowLen <= 7'd99 && windowLen != 7'd0)
      else $error("window setting out of range");
   afac_a: assert property (@(posedge clk) disable iff (!resetn)
      aFactor <= 7'd99) else $error("factor out of range");
   pass_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_CALC && windowLen == 7'd1) |=>
      adaptiveAverageOutput == $past(latched))
      else $error("window one not raw");
   steady_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_CALC && ratio == 8'h00) |=> accum == 8'h00)
      else $error("steady flow not cleared");
   noaccel_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_CALC && aFactor == 7'h00 && windowLen != 7'd1) |=>
      adaptiveAverageOutput == plainAverageOutput)
      else $error("factor zero not plain");
   refnext_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_CALC && over) |=> pendRef ##0
      (refFlow == $past(refFlow)))
      else $error("reference moved early");
   restart_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_CALC && over) |=> fillCount == 7'h01)
      else $error("window not restarted");
   crossraw_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_CALC && over) |=>
      plainAverageOutput == $past(latched))
      else $error("plain not raw on crossing");

   // detector bookkeeping
   accum_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_CALC && aFactor != 7'h00 && ratio != 8'h00 && !over)
      |=> accum == $past(accSum[7:0]))
      else $error("ratio not accumulated");
   refload_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_CALC && pendRef) |=>
      refFlow == $past(adaptiveAverageOutput))
      else $error("reference not last output");
   steadyref_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == AFAF_CALC && aFactor != 7'h00 && ratio == 8'h00) |=>
      pendRef)
      else $error("steady flow kept reference");
endmodule // afaf_filter

// >>> afaf_front_end.sv
// behavioural flow front end handing raw samples to the filter
`timescale 1ns/1ns
module afaf_front_end (
   // clock
   input wire logic clk,
   // raw sample stream
   output logic sampleValid,
   output logic signed [15:0] sampleData
);
   // idle until the first request
   initial begin
      sampleValid = 1'b0;
      sampleData = 16'h0000;
   end
   // gap of idle cycles, then a one-cycle strobe; data flips after it
   // so a stale value can never pass for a held one
   task automatic deliver(input logic signed [15:0] v, input int gap);
      repeat (gap + 1) @(posedge clk);
      sampleValid <= 1'b1;
      sampleData <= v;
      @(posedge clk);
      sampleValid <= 1'b0;
      sampleData <= ~v;
   endtask
endmodule // afaf_front_end

// >>> afaf_filter_tb_top.sv
// self-checking bench for the adaptive flow average filter
`timescale 1ns/1ns
module afaf_filter_tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0000_0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic sampleValid;
   logic signed [15:0] sampleData;
   logic outValid;
   logic periodTick;
   logic signed [15:0] plainAverageOutput;
   logic signed [15:0] adaptiveAverageOutput;
   logic [31:0] seed = 32'h0000_9afc;
   logic [31:0] rv;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   int tickGap = 1000;
   int hist[$];
   int c;
   int d;
   // 25 MHz clock
   always #20 clk = ~clk;
   afaf_front_end fe_u (.clk(clk), .sampleValid(sampleValid),
      .sampleData(sampleData));
   // short period so tick spacing is seen quickly
   afaf_filter #(.PERIOD_CYC(10)) dut_u (.clk(clk), .resetn(resetn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .sampleValid(sampleValid),
      .sampleData(sampleData), .outValid(outValid),
      .plainAverageOutput(plainAverageOutput),
      .adaptiveAverageOutput(adaptiveAverageOutput),
      .periodTick(periodTick));
   // xorshift source with fixed start
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // mean of the last w samples fed
   function automatic int expMean(int w);
      int s = 0;
      for (int i = 0; i < w; i++) s += hist[hist.size() - 1 - i];
      return s / w;
   endfunction
   // half-way step toward raw
   function automatic int expStep(int p, int r);
      return p + ((r - p) >>> 1);
   endfunction
   task automatic chk(input bit ok, input string m);
      checks++;
      if (!ok) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // register write: one cycle with strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // register read: data stands only in the following cycle
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata === e, "register read");
   endtask
   // one sample through the front end, bounded wait for the result
   task automatic feed(input int v);
      int n = 0;
      hist.push_back(v);
      rv = rnd();
      fe_u.deliver(16'(v), int'(rv[1:0]));
      do begin
         @(posedge clk);
         #1 n++;
      end while (outValid !== 1'b1 && n < 8);
      chk(outValid === 1'b1, "no result");
   endtask
   // tick spacing; first tick only starts the count
   always @(posedge clk) begin
      tickGap++;
      if (periodTick === 1'b1) begin
         if (tickGap < 100) chk(tickGap === 10, "tick spacing");
         tickGap = 0;
      end
   end
   // hang guard, well above the few hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         n_errors++;
         $display("[FAIL] %0t timeout", $time);
         finish_test();
      end
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rdChk(8'h00, 32'h0000_0001);
      rdChk(8'h04, 32'h0000_0000);
      rdChk(8'h08, 32'h0000_0001);
      rdChk(8'h18, 32'h0000_0000);
      // window one: both outputs follow raw exactly
      for (int i = 0; i < 8; i++) begin
         rv = rnd();
         c = int'($signed(rv[11:0]));
         feed(c);
         chk(plainAverageOutput === 16'(c), "plain not raw");
         chk(adaptiveAverageOutput === 16'(c), "adapt not raw");
      end
      // one past the limit on both settings
      wr(8'h00, 32'h0000_0064);
      rdChk(8'h00, 32'h0000_0063);
      wr(8'h04, 32'h0000_0064);
      rdChk(8'h04, 32'h0000_0063);
      wr(8'h04, 32'h0000_0000);
      wr(8'h00, 32'h0000_0004);
      // step response of a four-sample window, multiples of four
      rv = rnd();
      c = 4 * int'(rv[5:0]);
      rv = rnd();
      d = 4 * int'(rv[5:0]) + 4;
      for (int i = 0; i < 8; i++) begin
         feed(i < 4 ? c : d);
         if (i >= 3) chk(plainAverageOutput === 16'(expMean(4)), "mean");
         chk(adaptiveAverageOutput === plainAverageOutput, "f0");
      end
      // band of twenty, threshold ten
      wr(8'h08, 32'h0000_000a);
      wr(8'h04, 32'h0000_000a);
      for (int i = 0; i < 12; i++) feed(0);
      chk(adaptiveAverageOutput === 16'sd0, "not settled");
      feed(15);
      chk(adaptiveAverageOutput === 16'(expMean(4)), "band");
      feed(170);
      chk(adaptiveAverageOutput === 16'(expStep(3, 170)), "step");
      // a steady sample must empty the accumulator
      feed(0);
      feed(200);
      chk(plainAverageOutput === 16'(expMean(4)), "acc kept");
      feed(-200);
      chk(plainAverageOutput === -16'sd200, "no cross");
      rdChk(8'h0c, 32'hffff_ff38);
      rdChk(8'h10, 32'(expStep(123, -200)));
      rdChk(8'h14, 32'h0000_0001);
      finish_test();
   end
endmodule // afaf_filter_tb_top
